// ===== src/fcs_pkg.sv
// Constants, types and helpers shared by the flash config/status bank.
package fcs_pkg;

  // ---------------------------------------------------------------
  // Link command codes
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_BLOCK_LOCK = 8'h36;
  localparam logic [7:0] CMD_BLOCK_UNLOCK = 8'h39;
  localparam logic [7:0] CMD_POWER_DOWN = 8'hb9;
  localparam logic [7:0] CMD_ULTRA_DOWN = 8'h79;
  localparam logic [7:0] CMD_WAKE = 8'hab;
  localparam logic [7:0] CMD_WR_CFG3 = 8'h11;
  localparam logic [7:0] CMD_RD_CFG3 = 8'h15;
  localparam logic [7:0] CMD_WR_CFG4 = 8'h71;
  localparam logic [7:0] CMD_RD_CFG4 = 8'h75;
  localparam logic [7:0] CMD_SEQ_PROG = 8'had;
  localparam logic [7:0] CMD_SEQ_EXIT = 8'h04;

  // ---------------------------------------------------------------
  // Frame geometry in link bits
  // ---------------------------------------------------------------
  localparam int CNT_W = 6;
  localparam int WORD_W = 40;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 8;
  localparam logic [5:0] LEN_NONE = 6'h00;
  localparam logic [5:0] LEN_CMD = 6'h08;
  localparam logic [5:0] LEN_CMD_DATA = 6'h10;
  localparam logic [5:0] LEN_CMD_ADDR = 6'h20;
  localparam logic [5:0] LEN_FULL = 6'h28;
  localparam logic [5:0] LEN_LAST = 6'h07;

  // ---------------------------------------------------------------
  // Register layout and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] CFG3_WR_MASK = 8'he4;
  localparam logic [7:0] CFG3_RESET = 8'h20;
  localparam logic [7:0] CFG4_WR_MASK = 8'h80;
  localparam logic [7:0] CFG4_RESET = 8'h00;
  localparam int CFG3_PIN_FUNC_BIT = 7;
  localparam int CFG3_DRV_LSB = 5;
  localparam int DRV_W = 2;
  localparam logic [1:0] DRV_RESERVED = 2'h0;
  localparam int CFG3_WPS_BIT = 2;
  localparam int CFG4_PDM_BIT = 7;
  localparam int CFG4_SPM_BIT = 6;
  localparam int BLOCK_LSB = 16;
  localparam int RANGE_W = 6;
  localparam int SNAP_W = 17;

  // Power state; codes walk in Gray order active, deep, ultra.
  typedef enum logic [1:0] {
    PD_ACTIVE = 2'h0,
    PD_DEEP = 2'h1,
    PD_ULTRA = 2'h3
  } fcs_pd_e;

  // Frame length in bits after which a command takes effect.
  function automatic logic [5:0] fcs_frame_len(input logic [7:0] cmd,
                                               input logic seq_on);
    logic [5:0] len;
    len = LEN_NONE;
    unique case (cmd)
      CMD_BLOCK_LOCK, CMD_BLOCK_UNLOCK: len = LEN_CMD_ADDR;
      CMD_POWER_DOWN, CMD_ULTRA_DOWN: len = LEN_CMD;
      CMD_WAKE, CMD_SEQ_EXIT: len = LEN_CMD;
      CMD_WR_CFG3, CMD_WR_CFG4: len = LEN_CMD_DATA;
      CMD_SEQ_PROG: len = seq_on ? LEN_CMD_DATA : LEN_FULL;
      default: len = LEN_NONE;
    endcase
    return len;
  endfunction

endpackage

// ===== src/fcs_sync.sv
// Two-flop level synchroniser, frozen by its enable.
`timescale 1ns/1ps
module fcs_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_en,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta_r;

  // -----------------------------------------------------------------
  // Synchroniser chain
  // -----------------------------------------------------------------
  // The first stage feeds only the second stage.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_r <= '0;
      o_q <= '0;
    end else if (i_en) begin
      meta_r <= i_d;
      o_q <= meta_r;
    end
  end
endmodule // fcs_sync

// ===== src/fcs_flash_cfg_regs.sv
// Pin, drive, protection, power-down and program-mode configuration bank.
`timescale 1ns/1ps
//
// Contract
// - Pin function bit: zero gives hold input, one gives reset input.
// - Hold/reset selection applies only while quad enable is clear.
// - Two-bit strength field: 01 full, 10 two-thirds, 11 one-third.
// - Scheme bit clear: range protection from the first status fields.
// - Scheme bit set: one independent lock bit per block.
// - All block lock bits are set at power-on and any device reset.
// - Commands 36h lock and 39h unlock the addressed block.
// - Scheme-free B9h with depth clear enters ultra-deep, buffer lost.
// - B9h with depth set enters deep power-down, buffer kept.
// - Only command ABh wakes the device from either power-down; a device reset from the shared pin also returns it to active here.
// - Toggling chip select alone never leaves power-down.
// - Sequential flag reads 0 in byte/page mode, 1 once entered.
// - Power-up or device reset clears the sequential flag.
// - Sequential mode: first frame carries address, later use own count.
// - Quad enable turns protect and hold pins into data lines two, three.
module fcs_flash_cfg_regs
  import fcs_pkg::*;
#(
  parameter int NUM_BLOCKS = 16,
  parameter int BLOCK_IDX_W = 4
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_clk_en,
  input wire logic i_spi_sck,
  input wire logic i_spi_cs_n,
  input wire logic i_spi_mosi,
  input wire logic i_hold_reset_n,
  input wire logic i_quad_enable_bit,
  input wire logic i_protect_complement_bit,
  input wire logic i_protect_block_size_bit,
  input wire logic i_protect_top_bottom_bit,
  input wire logic [2:0] i_protect_range_field,
  output logic o_spi_miso,
  output logic o_spi_miso_oe,
  output logic [7:0] o_pin_drive_protect_config,
  output logic [7:0] o_power_program_mode_config,
  output logic o_hold_active,
  output logic o_pin_reset_req,
  output logic o_io23_data_mode,
  output logic [1:0] o_output_strength_field,
  output logic o_block_scheme_on,
  output logic [RANGE_W-1:0] o_range_protect,
  output logic [NUM_BLOCKS-1:0] o_block_locks,
  output logic [1:0] o_power_state,
  output logic o_sram_buf_lost,
  output logic o_prog_valid,
  output logic [ADDR_W-1:0] o_prog_addr,
  output logic [DATA_W-1:0] o_prog_data
);

  // -----------------------------------------------------------------
  // Link domain: frame capture
  // -----------------------------------------------------------------
  logic frame_rst;
  logic [WORD_W-2:0] shift_r;
  logic [CNT_W-1:0] cnt_r;
  logic [7:0] cmd_r;
  logic [7:0] cur_cmd;
  logic [5:0] cur_len;
  logic [WORD_W-1:0] cur_word;
  logic [SNAP_W-1:0] snap_s;
  logic link_spm;
  logic link_asleep;
  logic [7:0] ev_cmd_r;
  logic [WORD_W-1:0] ev_word_r;
  logic ev_addr_r;
  logic ev_tgl_r;
  logic [7:0] tx_r;

  // A raised chip select clears the frame; sck may stop between frames.
  assign frame_rst = i_spi_cs_n | i_rst;
  assign cur_cmd = (cnt_r == LEN_LAST) ? {shift_r[6:0], i_spi_mosi} : cmd_r;
  assign link_spm = snap_s[8 + CFG4_SPM_BIT];
  assign link_asleep = snap_s[SNAP_W-1];
  assign cur_len = fcs_frame_len(cur_cmd, link_spm);
  assign cur_word = {shift_r, i_spi_mosi};

  // Shift register and bit counter, saturating at the longest frame.
  always_ff @(posedge i_spi_sck or posedge frame_rst) begin
    if (frame_rst) begin
      shift_r <= '0;
      cnt_r <= '0;
      cmd_r <= '0;
    end else begin
      shift_r <= cur_word[WORD_W-2:0];
      if (cnt_r != LEN_FULL) begin
        cnt_r <= cnt_r + 6'h01;
      end
      if (cnt_r == LEN_LAST) begin
        cmd_r <= cur_cmd;
      end
    end
  end

  // Completed commands are posted by toggle; payload is held stable
  // across frames so the system side may read it after the toggle.
  always_ff @(posedge i_spi_sck or posedge i_rst) begin
    if (i_rst) begin
      ev_cmd_r <= '0;
      ev_word_r <= '0;
      ev_addr_r <= 1'b0;
      ev_tgl_r <= 1'b0;
    end else if (!i_spi_cs_n && cur_len != LEN_NONE
                 && cnt_r + 6'h01 == cur_len) begin
      ev_cmd_r <= cur_cmd;
      ev_word_r <= cur_word;
      ev_addr_r <= (cur_len == LEN_FULL);
      ev_tgl_r <= ~ev_tgl_r;
    end
  end

  // Register contents reach the link through two flops; they only move
  // after a write frame has ended, long before the next read starts.
  fcs_sync #(.W(SNAP_W)) u_snap_sync (
    .i_clk(i_spi_sck),
    .i_rst(i_rst),
    .i_en(1'b1),
    .i_d({o_power_state != PD_ACTIVE, o_power_program_mode_config,
          o_pin_drive_protect_config}),
    .o_q(snap_s)
  );

  // Read data leaves on the falling edge; a sleeping device stays silent.
  always_ff @(negedge i_spi_sck or posedge frame_rst) begin
    if (frame_rst) begin
      tx_r <= '0;
      o_spi_miso <= 1'b0;
      o_spi_miso_oe <= 1'b0;
    end else if (cnt_r == LEN_CMD && !link_asleep
                 && (cmd_r == CMD_RD_CFG3 || cmd_r == CMD_RD_CFG4)) begin
      tx_r <= (cmd_r == CMD_RD_CFG3) ? {snap_s[6:0], 1'b0}
                                    : {snap_s[14:8], 1'b0};
      o_spi_miso <= (cmd_r == CMD_RD_CFG3) ? snap_s[7] : snap_s[15];
      o_spi_miso_oe <= 1'b1;
    end else if (o_spi_miso_oe) begin
      o_spi_miso <= tx_r[7];
      tx_r <= {tx_r[6:0], 1'b0};
    end
  end

  // -----------------------------------------------------------------
  // System domain: event receipt and pin sampling
  // -----------------------------------------------------------------
  logic tgl_s;
  logic tgl_seen_r;
  logic pin_s;
  logic dev_rst;
  logic ev_new;
  logic act;
  logic awake;
  logic [7:0] cfg3_r;
  logic [7:0] cfg4_r;
  logic [7:0] cfg3_nxt;
  logic [ADDR_W-1:0] seq_addr_r;
  logic [BLOCK_IDX_W-1:0] blk_idx;
  fcs_pd_e pd_r;

  fcs_sync #(.W(1)) u_tgl_sync (
    .i_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_en(i_clk_en),
    .i_d(ev_tgl_r),
    .o_q(tgl_s)
  );

  fcs_sync #(.W(1)) u_pin_sync (
    .i_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_en(i_clk_en),
    .i_d(i_hold_reset_n),
    .o_q(pin_s)
  );

  // Shared pin acts as reset only with quad off and function bit set.
  assign dev_rst = !i_quad_enable_bit && cfg3_r[CFG3_PIN_FUNC_BIT]
                   && !pin_s;
  assign ev_new = tgl_s ^ tgl_seen_r;
  assign act = ev_new && !dev_rst;
  assign awake = (pd_r == PD_ACTIVE);
  assign blk_idx = ev_word_r[BLOCK_LSB +: BLOCK_IDX_W];

  // A reserved strength code leaves the current strength in place.
  always_comb begin
    cfg3_nxt = ev_word_r[7:0] & CFG3_WR_MASK;
    if (cfg3_nxt[CFG3_DRV_LSB +: DRV_W] == DRV_RESERVED) begin
      cfg3_nxt[CFG3_DRV_LSB +: DRV_W] = cfg3_r[CFG3_DRV_LSB +: DRV_W];
    end
  end

  // Each event is consumed exactly once.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      tgl_seen_r <= 1'b0;
    end else if (i_clk_en) begin
      tgl_seen_r <= tgl_s;
    end
  end

  // -----------------------------------------------------------------
  // Configuration registers
  // -----------------------------------------------------------------
  // Pin/drive/scheme register; reserved bits never take a one.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      cfg3_r <= CFG3_RESET;
    end else if (i_clk_en && act && awake && ev_cmd_r == CMD_WR_CFG3) begin
      cfg3_r <= cfg3_nxt;
    end
  end

  // Depth bit is writable; the sequential flag is set by hardware only.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      cfg4_r <= CFG4_RESET;
    end else if (i_clk_en) begin
      if (dev_rst) begin
        cfg4_r[CFG4_SPM_BIT] <= 1'b0;
      end else if (act && awake) begin
        if (ev_cmd_r == CMD_WR_CFG4) begin
          cfg4_r[CFG4_PDM_BIT] <= ev_word_r[CFG4_PDM_BIT];
        end else if (ev_cmd_r == CMD_SEQ_PROG && ev_addr_r) begin
          cfg4_r[CFG4_SPM_BIT] <= 1'b1;
        end else if (ev_cmd_r == CMD_SEQ_EXIT) begin
          cfg4_r[CFG4_SPM_BIT] <= 1'b0;
        end
      end
    end
  end

  // -----------------------------------------------------------------
  // Power-down state
  // -----------------------------------------------------------------
  // While asleep every command but wake is dropped, so a bare chip
  // select pulse, which posts no event, cannot wake the device.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      pd_r <= PD_ACTIVE;
      o_sram_buf_lost <= 1'b0;
    end else if (i_clk_en) begin
      o_sram_buf_lost <= 1'b0;
      if (dev_rst) begin
        pd_r <= PD_ACTIVE;
      end else if (act) begin
        unique case (pd_r)
          PD_ACTIVE: begin
            if (ev_cmd_r == CMD_ULTRA_DOWN || (ev_cmd_r == CMD_POWER_DOWN
                && !cfg4_r[CFG4_PDM_BIT])) begin
              pd_r <= PD_ULTRA;
              o_sram_buf_lost <= 1'b1;
            end else if (ev_cmd_r == CMD_POWER_DOWN) begin
              pd_r <= PD_DEEP;
            end
          end
          PD_DEEP, PD_ULTRA: begin
            if (ev_cmd_r == CMD_WAKE) begin
              pd_r <= PD_ACTIVE;
            end
          end
          default: pd_r <= PD_ACTIVE;
        endcase
      end
    end
  end

  // -----------------------------------------------------------------
  // Block locks and sequential programming
  // -----------------------------------------------------------------
  // Locks come up all set; lock commands count only under the scheme.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_block_locks <= '1;
    end else if (i_clk_en) begin
      if (dev_rst) begin
        o_block_locks <= '1;
      end else if (act && awake && cfg3_r[CFG3_WPS_BIT]
                   && (ev_cmd_r == CMD_BLOCK_LOCK
                       || ev_cmd_r == CMD_BLOCK_UNLOCK)) begin
        o_block_locks[blk_idx] <= (ev_cmd_r == CMD_BLOCK_LOCK);
      end
    end
  end

  // The first frame loads the address; later ones use the own count.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      seq_addr_r <= '0;
      o_prog_valid <= 1'b0;
      o_prog_addr <= '0;
      o_prog_data <= '0;
    end else if (i_clk_en) begin
      o_prog_valid <= 1'b0;
      if (dev_rst) begin
        seq_addr_r <= '0;
      end else if (act && awake && ev_cmd_r == CMD_SEQ_PROG) begin
        o_prog_valid <= 1'b1;
        o_prog_data <= ev_word_r[DATA_W-1:0];
        if (ev_addr_r) begin
          o_prog_addr <= ev_word_r[DATA_W +: ADDR_W];
          seq_addr_r <= ev_word_r[DATA_W +: ADDR_W] + 24'h000001;
        end else begin
          o_prog_addr <= seq_addr_r;
          seq_addr_r <= seq_addr_r + 24'h000001;
        end
      end
    end
  end

  // -----------------------------------------------------------------
  // Pin functions and registered views
  // -----------------------------------------------------------------
  // Quad mode hands both pins to the data path and kills their roles.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_hold_active <= 1'b0;
      o_pin_reset_req <= 1'b0;
      o_io23_data_mode <= 1'b0;
      o_block_scheme_on <= 1'b0;
      o_range_protect <= '0;
    end else if (i_clk_en) begin
      o_hold_active <= !i_quad_enable_bit && !cfg3_r[CFG3_PIN_FUNC_BIT]
                       && !pin_s;
      o_pin_reset_req <= dev_rst;
      o_io23_data_mode <= i_quad_enable_bit;
      o_block_scheme_on <= cfg3_r[CFG3_WPS_BIT];
      o_range_protect <= cfg3_r[CFG3_WPS_BIT] ? '0 :
        {i_protect_complement_bit, i_protect_block_size_bit,
         i_protect_top_bottom_bit, i_protect_range_field};
    end
  end

  assign o_pin_drive_protect_config = cfg3_r;
  assign o_power_program_mode_config = cfg4_r;
  assign o_output_strength_field = cfg3_r[CFG3_DRV_LSB +: DRV_W];
  assign o_power_state = pd_r;

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  a_hold_select: assert property (i_clk_en && !i_quad_enable_bit
      && !cfg3_r[CFG3_PIN_FUNC_BIT] && !pin_s |=> o_hold_active)
    else $error("hold not asserted");
  a_quad_pins_off: assert property (i_clk_en && i_quad_enable_bit
      |=> !o_hold_active && !o_pin_reset_req && o_io23_data_mode)
    else $error("pin role active in quad mode");
  a_drive_code: assert property (
      o_output_strength_field != DRV_RESERVED)
    else $error("reserved strength code held");
  a_reserved_zero: assert property (
      (cfg3_r & ~CFG3_WR_MASK) == 8'h00)
    else $error("reserved bit set");
  a_range_gate: assert property (i_clk_en && cfg3_r[CFG3_WPS_BIT]
      |=> o_range_protect == '0 && o_block_scheme_on)
    else $error("range fields pass under block scheme");
  a_locks_reset: assert property (i_clk_en && dev_rst
      |=> &o_block_locks ##1 !i_clk_en || !dev_rst || &o_block_locks)
    else $error("locks not set by reset");
  a_lock_cmd: assert property (i_clk_en && act && awake
      && cfg3_r[CFG3_WPS_BIT] && ev_cmd_r == CMD_BLOCK_UNLOCK
      |=> !o_block_locks[$past(blk_idx)])
    else $error("unlock missed");
  a_ultra_entry: assert property (i_clk_en && act && awake
      && ev_cmd_r == CMD_POWER_DOWN && !cfg4_r[CFG4_PDM_BIT]
      |=> pd_r == PD_ULTRA && o_sram_buf_lost)
    else $error("ultra-deep not entered");
  a_deep_entry: assert property (i_clk_en && act && awake
      && ev_cmd_r == CMD_POWER_DOWN && cfg4_r[CFG4_PDM_BIT]
      |=> pd_r == PD_DEEP && !o_sram_buf_lost)
    else $error("deep power-down not entered");
  a_stay_asleep: assert property (!awake && !dev_rst
      && !(ev_new && ev_cmd_r == CMD_WAKE) |=> pd_r == $past(pd_r))
    else $error("woke without wake command");
  a_spm_cleared: assert property (i_clk_en && dev_rst
      |=> !cfg4_r[CFG4_SPM_BIT])
    else $error("sequential flag kept over reset");
  a_seq_addr: assert property (i_clk_en && act && awake
      && ev_cmd_r == CMD_SEQ_PROG && !ev_addr_r
      |=> o_prog_valid && o_prog_addr == $past(seq_addr_r))
    else $error("sequential address wrong");

  c_lock: cover property (act && ev_cmd_r == CMD_BLOCK_LOCK
                          && cfg3_r[CFG3_WPS_BIT]);
  c_sleep_wake: cover property (pd_r == PD_DEEP ##[1:1000]
                                pd_r == PD_ACTIVE);
  c_seq_two: cover property (o_prog_valid ##[1:1000] o_prog_valid
                             && cfg4_r[CFG4_SPM_BIT]);
  c_pin_reset: cover property (o_pin_reset_req);

endmodule // fcs_flash_cfg_regs

// ===== verif/fcs_spi_host.sv
// Behavioural link host that shifts frames into the configuration bank.
`timescale 1ns/1ps
module fcs_spi_host (
  output logic o_spi_sck,
  output logic o_spi_cs_n,
  output logic o_spi_mosi,
  input wire logic i_spi_miso,
  input wire logic i_spi_miso_oe
);
  // ---------------------------------------------------------------
  // Idle levels
  // ---------------------------------------------------------------
  // The link clock stands still low between frames, as in mode 0.
  initial begin
    o_spi_sck = 1'b0;
    o_spi_cs_n = 1'b1;
    o_spi_mosi = 1'b0;
  end

  // ---------------------------------------------------------------
  // Frame transfer
  // ---------------------------------------------------------------
  // Sends n bits MSB first at a 160 ns period and captures the answer.
  // The data line is inverted once released, so no stale bit lingers.
  task automatic xfer(input logic [39:0] tx, input int n,
                      output logic [7:0] rx);
    rx = 8'h00;
    o_spi_cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      o_spi_mosi = tx[39-i];
      #80 o_spi_sck = 1'b1;
      if (i >= 8 && i_spi_miso_oe === 1'b1) begin
        rx = {rx[6:0], i_spi_miso};
      end
      #80 o_spi_sck = 1'b0;
    end
    #20 o_spi_cs_n = 1'b1;
    o_spi_mosi = ~o_spi_mosi;
    #60;
  endtask
endmodule // fcs_spi_host

// ===== verif/tb_flash_cfg_status_regs.sv
// Self-checking bench for the flash configuration and status bank.
`timescale 1ns/1ps
module tb_flash_config_status_regs;
  import fcs_pkg::*;
  logic i_sys_clk = 1'b0, i_rst = 1'b1, hold_n = 1'b1, quad = 1'b0;
  logic en = 1'b1;
  logic [5:0] rng = 6'h2d;
  logic sck, cs_n, mosi, miso, oe;
  logic [7:0] cfg3, cfg4, rx, pdat;
  logic [15:0] locks;
  logic [1:0] pst, strg;
  logic hold_act, pin_rst, io23, bscheme, plost;
  logic [5:0] rprot;
  logic [23:0] paddr;
  int mismatches = 0, total_checks = 0, lost_cnt = 0;

  // ---------------------------------------------------------------
  // Clock, partner and device
  // ---------------------------------------------------------------
  always #2 i_sys_clk = ~i_sys_clk;
  fcs_spi_host u_host (.o_spi_sck(sck), .o_spi_cs_n(cs_n),
    .o_spi_mosi(mosi), .i_spi_miso(miso), .i_spi_miso_oe(oe));
  fcs_flash_cfg_regs u_dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
    .i_clk_en(en), .i_spi_sck(sck), .i_spi_cs_n(cs_n),
    .i_spi_mosi(mosi), .i_hold_reset_n(hold_n),
    .i_quad_enable_bit(quad), .i_protect_complement_bit(rng[5]),
    .i_protect_block_size_bit(rng[4]), .i_protect_top_bottom_bit(rng[3]),
    .i_protect_range_field(rng[2:0]), .o_spi_miso(miso),
    .o_spi_miso_oe(oe), .o_pin_drive_protect_config(cfg3),
    .o_power_program_mode_config(cfg4), .o_hold_active(hold_act),
    .o_pin_reset_req(pin_rst), .o_io23_data_mode(io23),
    .o_output_strength_field(strg), .o_block_scheme_on(bscheme),
    .o_range_protect(rprot), .o_block_locks(locks), .o_power_state(pst),
    .o_sram_buf_lost(plost), .o_prog_valid(), .o_prog_addr(paddr),
    .o_prog_data(pdat));

  // Program strobes last one cycle, so the bench keeps what they carried.
  logic [31:0] prog_seen;
  always @(posedge i_sys_clk) if (u_dut.o_prog_valid === 1'b1) begin
    prog_seen <= {paddr, pdat};
  end
  // Buffer-loss pulses are counted, so each entry is seen exactly once.
  always @(posedge i_sys_clk) if (plost === 1'b1) lost_cnt <= lost_cnt + 1;

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  // A command frame, then time for the crossing and the update to land.
  task automatic cmd(input logic [39:0] tx, input int n);
    u_host.xfer(tx, n, rx);
    repeat (8) @(posedge i_sys_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] op, d);
    cmd({op, d, 24'h0}, 16);
  endtask
  task automatic rd(input logic [7:0] op, output logic [7:0] v);
    u_host.xfer({op, 32'h0}, 16, v);
  endtask
  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Watchdog at nearly four times the 81 us that the frames should take.
  initial begin
    #300us;
    mismatches++;
    wrap_up();
  end

  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (12) @(posedge i_sys_clk);
    #1 i_rst = 1'b0;
    repeat (4) @(posedge i_sys_clk);
    #1;
    chk("cfg3 reset", 8'h20, cfg3);
    chk("locks reset", 16'hffff, locks);
    chk("cfg4 reset", 8'h00, cfg4);
    $display("test reset values done");
    // Reserved bits stay zero; every strength code, 00 refused.
    wr(CMD_WR_CFG3, 8'hff);
    rd(CMD_RD_CFG3, rx);
    chk("cfg3 read", 8'he4, rx);
    for (int c = 1; c < 4; c++) begin
      wr(CMD_WR_CFG3, {1'b0, c[1:0], 5'h1b});
      chk("strength", c, strg);
      chk("cfg3 reserved", 0, cfg3 & 8'h1b);
    end
    wr(CMD_WR_CFG3, 8'h00);
    chk("strength 00", 2'h3, strg);
    $display("test register fields done");
    // Range scheme: range follows inputs, lock commands ignored.
    cmd({CMD_BLOCK_UNLOCK, 24'h030000, 8'h0}, 32);
    chk("range", 6'h2d, rprot);
    chk("locks range", 16'hffff, locks);
    chk("scheme off", 1'b0, bscheme);
    wr(CMD_WR_CFG3, 8'h24);
    chk("range off", 6'h00, rprot);
    chk("scheme on", 1'b1, bscheme);
    cmd({CMD_BLOCK_UNLOCK, 24'h030000, 8'h0}, 32);
    cmd({CMD_BLOCK_UNLOCK, 24'h0f0000, 8'h0}, 32);
    chk("unlock", 16'h7ff7, locks);
    cmd({CMD_BLOCK_LOCK, 24'h030000, 8'h0}, 32);
    chk("lock", 16'h7fff, locks);
    $display("test block protection done");
    // Sequential program: first frame addressed, later ones not.
    cmd({CMD_SEQ_PROG, 24'h01fffe, 8'h5a}, 40);
    chk("seq flag", 8'h40, cfg4);
    rd(CMD_RD_CFG4, rx);
    chk("cfg4 read", 8'h40, rx);
    chk("first prog", {24'h01fffe, 8'h5a}, prog_seen);
    cmd({CMD_SEQ_PROG, 8'ha5, 24'h0}, 16);
    chk("next prog", {24'h01ffff, 8'ha5}, prog_seen);
    cmd({CMD_SEQ_EXIT, 32'h0}, 8);
    chk("seq exit", 8'h00, cfg4);
    $display("test sequential program done");
    // Power-down depth, wake only by ABh, commands dropped meanwhile.
    cmd({CMD_POWER_DOWN, 32'h0}, 8);
    chk("ultra", PD_ULTRA, pst);
    chk("buf lost", 1, lost_cnt);
    cmd({CMD_WR_CFG4, 8'h80, 24'h0}, 16);
    rd(CMD_RD_CFG3, rx);
    chk("asleep read", 8'h00, rx);
    u_host.xfer(40'h0, 0, rx);
    repeat (8) @(posedge i_sys_clk);
    #1;
    chk("still down", PD_ULTRA, pst);
    chk("cfg4 dropped", 8'h00, cfg4);
    cmd({CMD_WAKE, 32'h0}, 8);
    chk("woke", PD_ACTIVE, pst);
    wr(CMD_WR_CFG4, 8'h80);
    cmd({CMD_POWER_DOWN, 32'h0}, 8);
    chk("deep", PD_DEEP, pst);
    chk("buf kept", 1, lost_cnt);
    cmd({CMD_WAKE, 32'h0}, 8);
    cmd({CMD_ULTRA_DOWN, 32'h0}, 8);
    chk("ultra cmd", PD_ULTRA, pst);
    chk("ultra lost", 2, lost_cnt);
    cmd({CMD_WAKE, 32'h0}, 8);
    $display("test power-down done");
    // Enable low freezes the bank; the pending write lands on release.
    @(posedge i_sys_clk) #1 en = 1'b0;
    wr(CMD_WR_CFG3, 8'h44);
    chk("frozen", 8'h24, cfg3);
    @(posedge i_sys_clk) #1 en = 1'b1;
    repeat (8) @(posedge i_sys_clk);
    #1;
    chk("thawed", 8'h44, cfg3);
    $display("test clock enable done");
    // Shared pin: hold, quad override, then device reset.
    cmd({CMD_SEQ_PROG, 24'h000100, 8'h11}, 40);
    @(posedge i_sys_clk) #1 hold_n = 1'b0;
    repeat (6) @(posedge i_sys_clk);
    #1;
    chk("hold", 2'h2, {hold_act, pin_rst});
    @(posedge i_sys_clk) #1 quad = 1'b1;
    repeat (6) @(posedge i_sys_clk);
    #1;
    chk("quad", 3'h1, {hold_act, pin_rst, io23});
    @(posedge i_sys_clk) #1 hold_n = 1'b1;
    quad = 1'b0;
    repeat (6) @(posedge i_sys_clk);
    #1;
    wr(CMD_WR_CFG3, 8'ha4);
    @(posedge i_sys_clk) #1 hold_n = 1'b0;
    repeat (6) @(posedge i_sys_clk);
    #1;
    chk("pin reset", 2'h1, {hold_act, pin_rst});
    chk("pin locks", 16'hffff, locks);
    chk("pin seq", 8'h80, cfg4);
    @(posedge i_sys_clk) #1 hold_n = 1'b1;
    $display("test shared pin done");
    wrap_up();
  end
endmodule // tb_flash_config_status_regs
